// ### design/dtc_timer_top.sv
// dual timer/counter with a classic wishbone slave for its registers
// assumes ref_clk is the oscillator; count and gate pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  output logic overflow_a,
  output logic overflow_b
);

  generate
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 5 and 32");
    end
  endgenerate

  // machine cycle timebase
  logic [2:0] mc_cnt_q;
  logic mc_tick;

  // pin synchronisers and machine cycle samples, index 0 is counter a
  logic [1:0] cnt_s1_q;
  logic [1:0] cnt_s2_q;
  logic [1:0] gate_s1_q;
  logic [1:0] gate_s2_q;
  logic [1:0] cnt_samp_q;
  logic [1:0] cnt_prev_q;
  logic [1:0] gate_samp_q;
  logic [1:0] fall_edge;

  // registers
  logic [7:0] mode_q;
  logic [1:0] run_q;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_mux;

  // per-counter control
  logic [1:0] gate_en;
  logic [1:0] src_ext;
  logic [1:0] run_ok;
  logic [1:0] inc;
  dtc_pkg::dtc_mode_e mode_a;
  dtc_pkg::dtc_mode_e mode_b;
  logic split_a;

  // bus decode
  logic acc;
  logic wr_fire;
  logic rd_start;
  logic [7:0] adr_byte;
  logic hit_mode;
  logic hit_run;
  logic hit_flag;
  logic hit_cnt_a;
  logic hit_cnt_b;

  dtc_unit_if u_if_a ();
  dtc_unit_if u_if_b ();

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_cnt_q <= 3'h0;
    end else if (mc_cnt_q == dtc_pkg::MC_LAST) begin
      mc_cnt_q <= 3'h0;
    end else begin
      mc_cnt_q <= mc_cnt_q + 3'h1;
    end
  end

  assign mc_tick = (mc_cnt_q == dtc_pkg::MC_LAST);

  // first stages feed the second stages only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_s1_q <= 2'h3;
      cnt_s2_q <= 2'h3;
      gate_s1_q <= 2'h0;
      gate_s2_q <= 2'h0;
    end else begin
      cnt_s1_q <= {count_pin_b, count_pin_a};
      cnt_s2_q <= cnt_s1_q;
      gate_s1_q <= {gate_input_b, gate_input_a};
      gate_s2_q <= gate_s1_q;
    end
  end

  // sample once per machine cycle, edge seen over two samples
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_samp_q <= 2'h3;
      cnt_prev_q <= 2'h3;
      gate_samp_q <= 2'h0;
    end else if (mc_tick) begin
      cnt_samp_q <= cnt_s2_q;
      cnt_prev_q <= cnt_samp_q;
      gate_samp_q <= gate_s2_q;
    end
  end

  // falling edge on the count pin
  assign fall_edge = cnt_prev_q & ~cnt_samp_q;

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      gate_en[t] = mode_q[t*dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_GATE_BIT];
      src_ext[t] = mode_q[t*dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_SRC_BIT];
      // gate pin high lets the count through
      run_ok[t] = run_q[t] & (~gate_en[t] | gate_samp_q[t]);
      // internal source, external edge, both one pulse per machine cycle
      inc[t] = run_ok[t] & mc_tick & (src_ext[t] ? fall_edge[t] : 1'b1);
    end
  end

  assign mode_a = dtc_pkg::dtc_mode_e'(mode_q[dtc_pkg::MODE_HIGH_BIT:dtc_pkg::MODE_LOW_BIT]);
  assign mode_b = dtc_pkg::dtc_mode_e'(
    mode_q[dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_HIGH_BIT:
           dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_LOW_BIT]);
  assign split_a = (mode_a == dtc_pkg::DTC_MODE_SPLIT);

  // bus decode; unmapped offsets answer with zero and ignore writes
  assign acc = wb_cyc_i & wb_stb_i;
  assign wr_fire = acc & wb_we_i & ack_q;
  assign rd_start = acc & ~ack_q;
  assign adr_byte = {{(8 - 5){1'b0}}, wb_adr_i[4:0]};
  assign hit_mode = (adr_byte == dtc_pkg::ADR_MODE) && (wb_adr_i[ADDR_W-1:5] == '0);
  assign hit_run = (adr_byte == dtc_pkg::ADR_RUN) && (wb_adr_i[ADDR_W-1:5] == '0);
  assign hit_flag = (adr_byte == dtc_pkg::ADR_FLAG) && (wb_adr_i[ADDR_W-1:5] == '0);
  assign hit_cnt_a = (adr_byte == dtc_pkg::ADR_COUNT_A) && (wb_adr_i[ADDR_W-1:5] == '0);
  assign hit_cnt_b = (adr_byte == dtc_pkg::ADR_COUNT_B) && (wb_adr_i[ADDR_W-1:5] == '0);

  // counter a: low half, and in split mode a high half on machine cycles
  assign u_if_a.mode = mode_a;
  assign u_if_a.inc = inc[0];
  // high half of a uses the run bit of counter b
  assign u_if_a.hi_inc = split_a & run_q[1] & mc_tick;
  assign u_if_a.wr_lo = wr_fire & hit_cnt_a & wb_sel_i[0];
  assign u_if_a.wr_hi = wr_fire & hit_cnt_a & wb_sel_i[1];
  assign u_if_a.wdata = wb_dat_i[15:0];

  assign u_if_b.mode = mode_b;
  assign u_if_b.inc = inc[1];
  assign u_if_b.hi_inc = 1'b0;
  assign u_if_b.wr_lo = wr_fire & hit_cnt_b & wb_sel_i[0];
  assign u_if_b.wr_hi = wr_fire & hit_cnt_b & wb_sel_i[1];
  assign u_if_b.wdata = wb_dat_i[15:0];

  dtc_count_unit #(
    .SPLIT_OK(1'b1)
  ) u_unit_a (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .u(u_if_a.unit)
  );

  // counter b halts in split mode
  dtc_count_unit #(
    .SPLIT_OK(1'b0)
  ) u_unit_b (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .u(u_if_b.unit)
  );

  // mode and run registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= dtc_pkg::MODE_RST;
    end else if (wr_fire && hit_mode && wb_sel_i[0]) begin
      mode_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= dtc_pkg::RUN_RST;
    end else if (wr_fire && hit_run && wb_sel_i[0]) begin
      run_q <= wb_dat_i[1:0];
    end
  end

  // overflow flags; while a is split its high half owns flag b
  assign flag_set[0] = u_if_a.ov_lo;
  assign flag_set[1] = split_a ? u_if_a.ov_hi : u_if_b.ov_lo;
  assign flag_clr = (wr_fire && hit_flag && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
  // a set in the clearing cycle survives
  assign flag_d = (flag_q & ~flag_clr) | flag_set;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= dtc_pkg::FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_mode) begin
      rd_mux = {24'h00_0000, mode_q};
    end else if (hit_run) begin
      rd_mux = {30'h0000_0000, run_q};
    end else if (hit_flag) begin
      rd_mux = {30'h0000_0000, flag_q};
    end else if (hit_cnt_a) begin
      rd_mux = {16'h0000, u_if_a.cnt_hi, u_if_a.cnt_lo};
    end else if (hit_cnt_b) begin
      rd_mux = {16'h0000, u_if_b.cnt_hi, u_if_b.cnt_lo};
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_start;
    end
  end

  // read data captured with the request; counts read lag the live value by one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_q <= 32'h0000_0000;
    end else if (rd_start) begin
      dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign overflow_a = flag_q[0];
  assign overflow_b = flag_q[1];

endmodule
`default_nettype wire

// ### design/dtc_pkg.sv
// constants, field layout, register offsets and mode codes of the dual timer/counter
// assumes a single ref_clk domain and a classic wishbone register port
// Function
// - mode 00: 8-bit counter behind a divide-by-32 prescaler
// - mode 10: 8-bit counter reloaded from an 8-bit value on overflow
// - mode 11: counter a splits into two 8-bit timers, counter b halts
// - count source bit zero: one increment per machine cycle, osc/6
// - counter function: increment on each falling edge of its count pin
// - edge detection takes two machine cycles; external rate at most osc/12
// - optional gate pin: count only while the gate pin is high
package dtc_pkg;

  // machine cycle length in oscillator periods
  localparam int OSC_PER_MC = 6;
  localparam logic [2:0] MC_LAST = 3'(OSC_PER_MC - 1);
  localparam int PRESCALE_BITS = 5;

  // register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_RUN = 8'h04;
  localparam logic [7:0] ADR_FLAG = 8'h08;
  localparam logic [7:0] ADR_COUNT_A = 8'h0C;
  localparam logic [7:0] ADR_COUNT_B = 8'h10;

  // timer_mode_control layout, one nibble per counter
  localparam int MODE_STRIDE = 4;
  localparam int MODE_LOW_BIT = 0;
  localparam int MODE_HIGH_BIT = 1;
  localparam int MODE_SRC_BIT = 2;
  localparam int MODE_GATE_BIT = 3;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] RUN_RST = 2'h0;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  // {mode_select_high, mode_select_low}
  typedef enum logic [1:0] {
    DTC_MODE_PRESC = 2'h0,
    DTC_MODE_FULL = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_e;

endpackage

// ### design/dtc_unit_if.sv
// signals between the timer top and one counting unit
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface dtc_unit_if;
  dtc_pkg::dtc_mode_e mode;
  logic inc;
  logic hi_inc;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wdata;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic ov_lo;
  logic ov_hi;

  modport ctrl (output mode, inc, hi_inc, wr_lo, wr_hi, wdata, input cnt_lo, cnt_hi, ov_lo, ov_hi);
  modport unit (input mode, inc, hi_inc, wr_lo, wr_hi, wdata, output cnt_lo, cnt_hi, ov_lo, ov_hi);
endinterface
`default_nettype wire

// ### design/dtc_count_unit.sv
// one counter: low and high byte with the four counting modes
// assumes increments arrive as single-cycle pulses from the top
`timescale 1ns/1ps
`default_nettype none
module dtc_count_unit #(
  parameter bit SPLIT_OK = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  dtc_unit_if.unit u
);

  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [12:0] c13;
  logic [15:0] c16;

  assign u.cnt_lo = lo_q;
  assign u.cnt_hi = hi_q;

  always_comb begin
    lo_d = lo_q;
    hi_d = hi_q;
    u.ov_lo = 1'b0;
    u.ov_hi = 1'b0;
    c13 = {hi_q, lo_q[dtc_pkg::PRESCALE_BITS-1:0]} + 13'h0001;
    c16 = {hi_q, lo_q} + 16'h0001;
    unique case (u.mode)
      dtc_pkg::DTC_MODE_PRESC: begin
        if (u.inc) begin
          lo_d = {lo_q[7:dtc_pkg::PRESCALE_BITS], c13[dtc_pkg::PRESCALE_BITS-1:0]};
          hi_d = c13[12:dtc_pkg::PRESCALE_BITS];
          u.ov_lo = (c13 == 13'h0000);
        end
      end
      dtc_pkg::DTC_MODE_FULL: begin
        if (u.inc) begin
          lo_d = c16[7:0];
          hi_d = c16[15:8];
          u.ov_lo = (c16 == 16'h0000);
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        if (u.inc) begin
          if (lo_q == dtc_pkg::BYTE_ONES) begin
            lo_d = hi_q;
            u.ov_lo = 1'b1;
          end else begin
            lo_d = lo_q + 8'h01;
          end
        end
      end
      // two 8-bit halves, or halted on the unit that cannot split
      dtc_pkg::DTC_MODE_SPLIT: begin
        if (SPLIT_OK) begin
          if (u.inc) begin
            lo_d = lo_q + 8'h01;
            u.ov_lo = (lo_q == dtc_pkg::BYTE_ONES);
          end
          if (u.hi_inc) begin
            hi_d = hi_q + 8'h01;
            u.ov_hi = (hi_q == dtc_pkg::BYTE_ONES);
          end
        end
      end
    endcase
    // software write wins over a coinciding increment
    if (u.wr_lo) begin
      lo_d = u.wdata[7:0];
    end
    if (u.wr_hi) begin
      hi_d = u.wdata[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_q <= dtc_pkg::COUNT_RST;
      hi_q <= dtc_pkg::COUNT_RST;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

endmodule
`default_nettype wire

// ### design/placeholder_none.sv
// intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### testbench/dtc_pin_model.sv
// far-side model: count pins and gate pins of both counters
// assumes ref_clk is the oscillator; pins rest high when idle
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic ref_clk,
  output logic cnt_a,
  output logic cnt_b,
  output logic gate_a,
  output logic gate_b
);
  initial begin
    cnt_a = 1'b1;
    cnt_b = 1'b1;
    gate_a = 1'b1;
    gate_b = 1'b1;
  end
  // falling edges, each level two machine cycles
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (12) @(posedge ref_clk);
      cnt_a <= 1'b0;
      cnt_b <= 1'b0;
      repeat (12) @(posedge ref_clk);
      cnt_a <= 1'b1;
      cnt_b <= 1'b1;
    end
  endtask
  task automatic gates(input logic a, input logic b);
    @(posedge ref_clk);
    gate_a <= a;
    gate_b <= b;
  endtask
endmodule
`default_nettype wire

// ### testbench/dtc_timer_properties.sv
// port checker for the timer top, bound below
// assumes ack one cycle after a request, flags sticky until cleared
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic overflow_a,
  input wire logic overflow_b
);
  localparam logic [ADDR_W-1:0] FLG = ADDR_W'(dtc_pkg::ADR_FLAG);
  localparam logic [ADDR_W-1:0] TOP = ADDR_W'(dtc_pkg::ADR_COUNT_B);
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  wire logic wflg = wb_ack_o && wb_we_i && wb_adr_i == FLG;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_ACK_AFTER_REQ: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_NO_ACK_IDLE: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  AST_WRITE_DATA_ZERO: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data on write");
  AST_UNMAPPED_ZERO: assert property (
    rd_ack && wb_adr_i[ADDR_W-1:2] > TOP[ADDR_W-1:2] |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FLAG_READ: assert property (rd_ack && wb_adr_i == FLG |->
    wb_dat_o == {30'h0, $past(overflow_b), $past(overflow_a)})
    else $error("flag read differs from pins");
  AST_A_STICKY: assert property ($fell(overflow_a) |-> $past(wflg && wb_dat_i[0]))
    else $error("overflow a dropped uncleared");
  AST_B_STICKY: assert property ($fell(overflow_b) |-> $past(wflg && wb_dat_i[1]))
    else $error("overflow b dropped uncleared");
endmodule
bind dtc_timer_top dtc_timer_checker #(.ADDR_W(ADDR_W)) i_dtc_timer_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_pin_a(count_pin_a),
  .count_pin_b(count_pin_b), .gate_input_a(gate_input_a), .gate_input_b(gate_input_b),
  .overflow_a(overflow_a), .overflow_b(overflow_b));
`default_nettype wire

// ### testbench/dtc_timer_top_tb_top.sv
// self-checking bench for the dual timer/counter
// assumes the pin model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pin_a, pin_b, gt_a, gt_b, ov_a, ov_b;
  logic [31:0] v0, v1, q;
  int failures = 0;
  int samples_checked = 0;

  dtc_timer_top i_dtc_timer_top (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .count_pin_a(pin_a), .count_pin_b(pin_b),
    .gate_input_a(gt_a), .gate_input_b(gt_b), .overflow_a(ov_a), .overflow_b(ov_b));
  dtc_pin_model i_dtc_pin_model (.ref_clk(ref_clk), .cnt_a(pin_a), .cnt_b(pin_b),
    .gate_a(gt_a), .gate_b(gt_b));

  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) failures++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  // request edges exactly 60 clocks apart: ten machine cycles
  task automatic meas(input logic [7:0] a);
    bus(1'b0, a, 32'h0, v0);
    repeat (57) @(posedge ref_clk);
    bus(1'b0, a, 32'h0, v1);
  endtask
  task automatic setup(input logic [7:0] m, input logic [31:0] ca, input logic [31:0] cb,
      input logic [31:0] run);
    wr(8'h04, 32'h0);
    wr(8'h00, {24'h0, m});
    wr(8'h0C, ca);
    wr(8'h10, cb);
    wr(8'h08, 32'h3);
    wr(8'h04, run);
  endtask

  task automatic t_reset;
    logic [7:0] al[7];
    al = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    foreach (al[i]) begin
      bus(1'b0, al[i], 32'h0, q);
      chk(q, 32'h0);
    end
  endtask
  task automatic t_full;
    setup(8'h11, 32'hFFF8, 32'hFFF8, 32'h3);
    meas(8'h0C);
    chk(16'(v1 - v0), 32'hA);
    chk({ov_b, ov_a}, 2'h3);
    wr(8'h08, 32'h3);
    @(posedge ref_clk);
    chk({ov_b, ov_a}, 2'h0);
  endtask
  task automatic t_presc;
    setup(8'h00, 32'h001C, 32'h0, 32'h1);
    meas(8'h0C);
    chk(13'({v1[15:8], v1[4:0]} - {v0[15:8], v0[4:0]}), 32'hA);
    chk(v1[7:5], 3'h0);
  endtask
  task automatic t_reload;
    logic [7:0] x;
    setup(8'h02, 32'hF0FA, 32'h0, 32'h1);
    meas(8'h0C);
    x = v0[7:0];
    repeat (10) x = (x == 8'hFF) ? 8'hF0 : x + 8'h01;
    chk(v1[15:0], {8'hF0, x});
    chk(ov_a, 1'b1);
  endtask
  task automatic t_split;
    setup(8'h33, 32'h1020, 32'h5555, 32'h3);
    meas(8'h0C);
    chk(8'(v1[7:0] - v0[7:0]), 32'hA);
    chk(8'(v1[15:8] - v0[15:8]), 32'hA);
    bus(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h5555);
  endtask
  task automatic t_pins;
    setup(8'h55, 32'h0, 32'h0, 32'h3);
    i_dtc_pin_model.pulses(5);
    repeat (24) @(posedge ref_clk);
    bus(1'b0, 8'h0C, 32'h0, q);
    chk(q, 32'h5);
    bus(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h5);
  endtask
  task automatic t_gate;
    setup(8'h99, 32'h0, 32'h0, 32'h0);
    i_dtc_pin_model.gates(1'b0, 1'b1);
    repeat (24) @(posedge ref_clk);
    wr(8'h04, 32'h3);
    meas(8'h0C);
    chk(16'(v1 - v0), 32'h0);
    meas(8'h10);
    chk(16'(v1 - v0), 32'hA);
    i_dtc_pin_model.gates(1'b1, 1'b0);
    repeat (24) @(posedge ref_clk);
    meas(8'h0C);
    chk(16'(v1 - v0), 32'hA);
    meas(8'h10);
    chk(16'(v1 - v0), 32'h0);
  endtask

  task automatic print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // bench needs under a thousand clocks; this is far beyond
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_full();
    t_presc();
    t_reload();
    t_split();
    t_pins();
    t_gate();
    print_verdict();
  end
endmodule
`default_nettype wire
